/* File: src/rss_cond_sel.sv */
// condition table lookup with negation for repeat and skip.
// assumes flags are already on the core clock.
`timescale 1ns/1ps
module rss_cond_sel import rss_pkg::*; (
  input wire logic [3:0] cond_field, // negate bit and condition code
  input wire rss_flags_s flags, // live condition sources
  output logic cond_true // evaluated condition
);
  logic raw;

  always_comb begin
    if (cond_field[2:0] == COND_CCA) begin
      raw = flags.cca;
    end else if (cond_field[2:0] == COND_SFD) begin
      raw = flags.sfd;
    end else if (cond_field[2:0] == COND_HOST) begin
      raw = flags.host;
    end else if (cond_field[2:0] == COND_RSVD) begin
      raw = 1'b0;
    end else if (cond_field[2:0] == COND_XZ) begin
      raw = flags.x_zero;
    end else if (cond_field[2:0] == COND_YZ) begin
      raw = flags.y_zero;
    end else if (cond_field[2:0] == COND_ZZ) begin
      raw = flags.z_zero;
    end else begin
      raw = flags.signal_level_valid;
    end
    cond_true = raw ^ cond_field[OP_NEG_BIT];
  end
endmodule

/* File: src/rss_pkg.sv */
// Functional notes
// - repeat jumps to loop label when condition holds
// - repeat advances if false or no label
// - three-bit code selects one of eight conditions
// - negate bit three inverts repeat and skip tests
// - skip advances count plus one when true
// - zero count skip busy-waits while true
// - skip beyond last instruction halts execution
// - stop opcode halts program execution
// - no-operation only advances program counter
// - rx on pulses output, waits for acknowledge
// - tx on waits; optionally raises mask bit
// - tx on only when channel clear
// - sample channel clear into status bit
// - radio off requests receive/transmit and synthesizer off
// - rx queue flush waits for acknowledge
// - tx queue flush waits for acknowledge
// - ack frames, pending clear/set, wait acknowledge
// - ack abort request to radio
// - program ops set/clear receive enable bit five
// - immediate ops set/clear bit five at once
// - immediate halt stops and raises halt flag
// - immediate run restarts at instruction zero
// - label records next address, one level
//
// constants, types and register map of the strobe sequencer.
// assumes one clock and an apb master with 32-bit data.
package rss_pkg;
  localparam int unsigned PROG_DEPTH = 24;
  localparam int unsigned PC_W = 5;
  localparam logic [PC_W-1:0] PROG_DEPTH_V = 5'h18;
  localparam int unsigned ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_IMM = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_STAT = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_PLEN = 12'h00c;
  localparam logic [ADDR_W-1:0] OFF_RXEN = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_XVAL = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_YREG = 12'h018;
  localparam logic [ADDR_W-1:0] OFF_ZREG = 12'h01c;
  localparam logic [ADDR_W-1:0] OFF_PROG = 12'h040;
  localparam logic [ADDR_W-1:0] OFF_PROG_END = 12'h0a0;
  localparam int CTRL_HOST_BIT = 0;
  localparam int CTRL_TXMASK_BIT = 1;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_HALT_BIT = 1;
  localparam int STAT_LABEL_BIT = 2;
  localparam int STAT_PC_LSB = 8;
  localparam int RXEN_SAMPLE_BIT = 8;
  localparam int RXEN_MASK_BIT = 5;
  localparam int OP_NEG_BIT = 3;
  localparam logic [7:0] OP_STOP = 8'hd2;
  localparam logic [7:0] OP_NOP = 8'hd0;
  localparam logic [7:0] OP_LABEL = 8'hbb;
  localparam logic [7:0] OP_MASK_SET = 8'hd4;
  localparam logic [7:0] OP_MASK_CLR = 8'hd5;
  localparam logic [7:0] OP_SAMPLE = 8'hdb;
  localparam logic [3:0] OP_REPEAT_HI = 4'ha;
  localparam logic [3:0] OP_STROBE_HI = 4'hd;
  localparam logic [7:0] IOP_RUN = 8'he1;
  localparam logic [7:0] IOP_HALT = 8'he2;
  localparam logic [7:0] IOP_RXON = 8'he3;
  localparam logic [7:0] IOP_MASK_SET = 8'he4;
  localparam logic [7:0] IOP_MASK_CLR = 8'he5;
  localparam logic [2:0] COND_CCA = 3'b000;
  localparam logic [2:0] COND_SFD = 3'b001;
  localparam logic [2:0] COND_HOST = 3'b010;
  localparam logic [2:0] COND_RSVD = 3'b011;
  localparam logic [2:0] COND_XZ = 3'b100;
  localparam logic [2:0] COND_YZ = 3'b101;
  localparam logic [2:0] COND_ZZ = 3'b110;
  localparam logic [2:0] COND_RSSI = 3'b111;

  // radio command codes equal the low nibble of the program opcode
  typedef enum logic [3:0] {
    CMD_RXON = 4'b0011, CMD_ACK = 4'b0110, CMD_ACKPEND = 4'b0111, CMD_NACK = 4'b1000,
    CMD_TXON = 4'b1001, CMD_TXONCCA = 4'b1010, CMD_FLUSHRX = 4'b1101, CMD_FLUSHTX = 4'b1110,
    CMD_RFOFF = 4'b1111
  } rss_cmd_e;

  typedef struct packed {
    logic valid;
    rss_cmd_e cmd;
  } rss_strobe_s;

  typedef struct packed {
    logic cca;
    logic sfd;
    logic host;
    logic x_zero;
    logic y_zero;
    logic z_zero;
    logic signal_level_valid;
  } rss_flags_s;

  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_RUN = 2'b01, ST_WAIT = 2'b10} rss_state_e;
endpackage

/* File: src/rss_sequencer.sv */
// command strobe sequencer: program store, execution, host immediate ops, apb slave.
// assumes radio flags and acknowledge come from logic on core_clk.
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
module rss_sequencer import rss_pkg::*; (
  input wire logic core_clk, // system clock, 125 mhz
  input wire logic rst_n, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic cca_in, // clear channel assessment
  input wire logic sfd_in, // start of frame active
  input wire logic signal_level_valid_in, // signal level valid
  input wire logic radio_ack, // radio accepted the last strobe
  output rss_strobe_s strobe_out, // command strobe to radio
  output logic rx_on_pulse_out, // receive enable pulse
  output logic [7:0] receive_enable_reg, // receive enable register
  output logic sampled_channel_clear, // last sampled channel clear value
  output logic halt_interrupt_flag, // sticky host halt flag
  output logic running // program executing
);
  logic [7:0] prog_mem [PROG_DEPTH];
  rss_state_e state_q;
  rss_state_e state_d;
  logic [PC_W-1:0] pc_q;
  logic [PC_W-1:0] pc_d;
  logic [PC_W-1:0] len_q;
  logic [PC_W-1:0] label_q;
  logic [PC_W-1:0] label_d;
  logic label_ok_q;
  logic label_ok_d;
  logic [1:0] ctrl_q;
  logic [7:0] rxen_q;
  logic sample_q;
  logic halt_flag_q;
  logic [7:0] xval_q;
  logic [7:0] yreg_q;
  logic [7:0] zreg_q;
  logic [31:0] prdata_q;

  // bus decode
  logic wr_en;
  logic rd_setup;
  logic sel_ctrl;
  logic sel_imm;
  logic sel_stat;
  logic sel_plen;
  logic sel_rxen;
  logic sel_x;
  logic sel_y;
  logic sel_z;
  logic sel_prog;
  logic mapped;
  logic [PC_W-1:0] prog_idx;
  logic [ADDR_W-1:0] prog_off;
  logic [31:0] rd_mux;

  // execution
  logic [7:0] instr;
  logic cond_true;
  rss_flags_s flags;
  rss_strobe_s prog_req;
  rss_strobe_s imm_req;
  logic [PC_W:0] pc_next;
  logic [PC_W:0] skip_tgt;
  logic prog_mask_set;
  logic prog_mask_clr;
  logic prog_sample;
  logic [7:0] imm_op;
  logic imm_wr;

  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign imm_op = pwdata[7:0];
  assign imm_wr = wr_en && sel_imm;

  always_comb begin
    sel_ctrl = 1'b0;
    sel_imm = 1'b0;
    sel_stat = 1'b0;
    sel_plen = 1'b0;
    sel_rxen = 1'b0;
    sel_x = 1'b0;
    sel_y = 1'b0;
    sel_z = 1'b0;
    sel_prog = 1'b0;
    prog_off = paddr - OFF_PROG;
    prog_idx = prog_off[PC_W+1:2];
    if (paddr == OFF_CTRL) begin
      sel_ctrl = 1'b1;
    end else if (paddr == OFF_IMM) begin
      sel_imm = 1'b1;
    end else if (paddr == OFF_STAT) begin
      sel_stat = 1'b1;
    end else if (paddr == OFF_PLEN) begin
      sel_plen = 1'b1;
    end else if (paddr == OFF_RXEN) begin
      sel_rxen = 1'b1;
    end else if (paddr == OFF_XVAL) begin
      sel_x = 1'b1;
    end else if (paddr == OFF_YREG) begin
      sel_y = 1'b1;
    end else if (paddr == OFF_ZREG) begin
      sel_z = 1'b1;
    end else if (paddr >= OFF_PROG && paddr < OFF_PROG_END && paddr[1:0] == 2'b00) begin
      sel_prog = 1'b1;
    end
    mapped = sel_ctrl | sel_imm | sel_stat | sel_plen | sel_rxen | sel_x | sel_y | sel_z | sel_prog;
  end

  assign pslverr = psel && penable && !mapped;

  always_comb begin
    rd_mux = '0;
    if (sel_ctrl) begin
      rd_mux[1:0] = ctrl_q;
    end else if (sel_stat) begin
      rd_mux[STAT_RUN_BIT] = (state_q != ST_IDLE);
      rd_mux[STAT_HALT_BIT] = halt_flag_q;
      rd_mux[STAT_LABEL_BIT] = label_ok_q;
      rd_mux[STAT_PC_LSB +: PC_W] = pc_q;
    end else if (sel_plen) begin
      rd_mux[PC_W-1:0] = len_q;
    end else if (sel_rxen) begin
      rd_mux[7:0] = rxen_q;
      rd_mux[RXEN_SAMPLE_BIT] = sample_q;
    end else if (sel_x) begin
      rd_mux[7:0] = xval_q;
    end else if (sel_y) begin
      rd_mux[7:0] = yreg_q;
    end else if (sel_z) begin
      rd_mux[7:0] = zreg_q;
    end else if (sel_prog) begin
      rd_mux[7:0] = prog_mem[prog_idx];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= '0;
    end else if (rd_setup) begin
      prdata_q <= rd_mux;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= '0;
      len_q <= '0;
      xval_q <= '0;
      yreg_q <= '0;
      zreg_q <= '0;
    end else if (wr_en) begin
      if (sel_ctrl) begin
        ctrl_q <= pwdata[1:0];
      end
      if (sel_plen) begin
        len_q <= (pwdata > 32'(PROG_DEPTH)) ? PROG_DEPTH_V : pwdata[PC_W-1:0];
      end
      if (sel_x) begin
        xval_q <= pwdata[7:0];
      end
      if (sel_y) begin
        yreg_q <= pwdata[7:0];
      end
      if (sel_z) begin
        zreg_q <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < PROG_DEPTH; i++) begin
        prog_mem[i] <= OP_NOP;
      end
    end else if (wr_en && sel_prog) begin
      prog_mem[prog_idx] <= pwdata[7:0];
    end
  end

  assign flags.cca = cca_in;
  assign flags.sfd = sfd_in;
  assign flags.host = ctrl_q[CTRL_HOST_BIT];
  assign flags.x_zero = (xval_q == 8'h00);
  assign flags.y_zero = (yreg_q == 8'h00);
  assign flags.z_zero = (zreg_q == 8'h00);
  assign flags.signal_level_valid = signal_level_valid_in;

  assign instr = prog_mem[pc_q];

  rss_cond_sel u_cond (
    .cond_field(instr[3:0]),
    .flags(flags),
    .cond_true(cond_true)
  );

  always_comb begin
    imm_req = '0;
    if (imm_wr && imm_op == IOP_RXON) begin
      imm_req.valid = 1'b1;
      imm_req.cmd = CMD_RXON;
    end
  end

  // one instruction per cycle; a host strobe in the same cycle holds the program back
  always_comb begin
    state_d = state_q;
    pc_d = pc_q;
    label_d = label_q;
    label_ok_d = label_ok_q;
    prog_req = '0;
    prog_mask_set = 1'b0;
    prog_mask_clr = 1'b0;
    prog_sample = 1'b0;
    pc_next = {1'b0, pc_q} + 6'h01;
    skip_tgt = {1'b0, pc_q} + {3'b000, instr[6:4]} + 6'h01;
    if (state_q == ST_RUN && !imm_req.valid) begin
      if (pc_next >= {1'b0, len_q}) begin
        state_d = ST_IDLE;
      end else begin
        pc_d = pc_next[PC_W-1:0];
      end
      if (!instr[7]) begin
        if (cond_true) begin
          if (instr[6:4] == 3'b000) begin
            state_d = ST_RUN;
            pc_d = pc_q;
          end else if (skip_tgt >= {1'b0, len_q}) begin
            state_d = ST_IDLE;
            pc_d = pc_q;
          end else begin
            state_d = ST_RUN;
            pc_d = skip_tgt[PC_W-1:0];
          end
        end
      end else if (instr[7:4] == OP_REPEAT_HI) begin
        if (cond_true && label_ok_q) begin
          state_d = ST_RUN;
          pc_d = label_q;
        end
      end else if (instr == OP_LABEL) begin
        label_ok_d = 1'b1;
        label_d = (pc_next >= {1'b0, PROG_DEPTH_V}) ? pc_q : pc_next[PC_W-1:0];
      end else if (instr == OP_STOP) begin
        state_d = ST_IDLE;
        pc_d = pc_q;
      end else if (instr == OP_MASK_SET) begin
        prog_mask_set = 1'b1;
      end else if (instr == OP_MASK_CLR) begin
        prog_mask_clr = 1'b1;
      end else if (instr == OP_SAMPLE) begin
        prog_sample = 1'b1;
      end else if (instr[7:4] == OP_STROBE_HI && instr != OP_NOP) begin
        prog_req.cmd = rss_cmd_e'(instr[3:0]);
        case (instr[3:0])
          CMD_RXON, CMD_FLUSHRX, CMD_FLUSHTX, CMD_ACK, CMD_ACKPEND: begin
            prog_req.valid = 1'b1;
            state_d = ST_WAIT;
            pc_d = pc_q;
          end
          CMD_TXON: begin
            prog_req.valid = 1'b1;
            prog_mask_set = ctrl_q[CTRL_TXMASK_BIT];
            state_d = ST_WAIT;
            pc_d = pc_q;
          end
          CMD_TXONCCA: begin
            prog_req.valid = cca_in;
          end
          CMD_RFOFF, CMD_NACK: begin
            prog_req.valid = 1'b1;
          end
          default: begin
            prog_req.valid = 1'b0;
          end
        endcase
      end
    end else if (state_q == ST_WAIT && radio_ack) begin
      if (pc_next >= {1'b0, len_q}) begin
        state_d = ST_IDLE;
      end else begin
        state_d = ST_RUN;
        pc_d = pc_next[PC_W-1:0];
      end
    end
    if (imm_wr && imm_op == IOP_HALT) begin
      state_d = ST_IDLE;
      label_ok_d = 1'b0;
    end else if (imm_wr && imm_op == IOP_RUN) begin
      pc_d = '0;
      label_ok_d = 1'b0;
      state_d = (len_q == '0) ? ST_IDLE : ST_RUN;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      pc_q <= '0;
    end else begin
      state_q <= state_d;
      pc_q <= pc_d;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      label_q <= '0;
      label_ok_q <= 1'b0;
    end else begin
      label_q <= label_d;
      label_ok_q <= label_ok_d;
    end
  end

  // host write first, then sequencer and immediate ops on the mask bit
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxen_q <= '0;
    end else begin
      if (wr_en && sel_rxen) begin
        rxen_q <= pwdata[7:0];
      end
      if (prog_mask_set || (imm_wr && imm_op == IOP_MASK_SET)) begin
        rxen_q[RXEN_MASK_BIT] <= 1'b1;
      end else if (prog_mask_clr || (imm_wr && imm_op == IOP_MASK_CLR)) begin
        rxen_q[RXEN_MASK_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_q <= 1'b0;
    end else if (prog_sample) begin
      sample_q <= cca_in;
    end
  end

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      halt_flag_q <= 1'b0;
    end else if (imm_wr && imm_op == IOP_HALT) begin
      halt_flag_q <= 1'b1;
    end else if (wr_en && sel_stat && pwdata[STAT_HALT_BIT]) begin
      halt_flag_q <= 1'b0;
    end
  end

  rss_strobe_out u_strobe (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .prog_req(prog_req),
    .imm_req(imm_req),
    .strobe_q(strobe_out),
    .rx_on_pulse_q(rx_on_pulse_out)
  );

  assign receive_enable_reg = rxen_q;
  assign sampled_channel_clear = sample_q;
  assign halt_interrupt_flag = halt_flag_q;
  assign running = (state_q != ST_IDLE);
endmodule

/* File: src/rss_strobe_out.sv */
// registers radio command strobes from program or host into one-cycle pulses.
// assumes the caller never raises both requests in one cycle.
`timescale 1ns/1ps
module rss_strobe_out import rss_pkg::*; (
  input wire logic core_clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire rss_strobe_s prog_req, // request from program execution
  input wire rss_strobe_s imm_req, // request from host immediate op
  output rss_strobe_s strobe_q, // one-cycle command strobe to radio
  output logic rx_on_pulse_q // one-cycle receive enable pulse
);
  rss_strobe_s pick;

  always_comb begin
    pick = imm_req.valid ? imm_req : prog_req;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_q <= '0;
    end else begin
      strobe_q <= pick;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_on_pulse_q <= 1'b0;
    end else begin
      rx_on_pulse_q <= pick.valid && (pick.cmd == CMD_RXON);
    end
  end
endmodule

/* File: verif/rss_props.sv */
// concurrent checks on the sequencer ports.
// assumes one core_clk domain and rst_n active low.
`timescale 1ns/1ps
module rss_props import rss_pkg::*; (
  input wire logic core_clk, // clock
  input wire logic rst_n, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [ADDR_W-1:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic cca_in, // clear channel
  input wire logic radio_ack, // radio acknowledge
  input wire rss_strobe_s strobe_out, // command strobe
  input wire logic rx_on_pulse_out, // receive pulse
  input wire logic [7:0] receive_enable_reg, // receive enable
  input wire logic halt_interrupt_flag, // halt flag
  input wire logic running // executing
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic imm_wr, run_wr, halt_wr, mset_wr, mclr_wr, wait_q;
  assign imm_wr = psel && penable && pwrite && paddr == OFF_IMM;
  assign run_wr = imm_wr && pwdata[7:0] == IOP_RUN;
  assign halt_wr = imm_wr && pwdata[7:0] == IOP_HALT;
  assign mset_wr = imm_wr && pwdata[7:0] == IOP_MASK_SET;
  assign mclr_wr = imm_wr && pwdata[7:0] == IOP_MASK_CLR;
  // high while a program strobe waits for the radio
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 1'b0;
    end else if (strobe_out.valid && running && strobe_out.cmd inside {CMD_RXON, CMD_TXON, CMD_ACK,
        CMD_ACKPEND, CMD_FLUSHRX, CMD_FLUSHTX}) begin
      wait_q <= 1'b1;
    end else if (radio_ack || !running) begin
      wait_q <= 1'b0;
    end
  end
  chk_rx_pulse: assert property (
    rx_on_pulse_out == (strobe_out.valid && strobe_out.cmd == CMD_RXON)) else $error("rx pulse mismatch");
  chk_run_start: assert property (
    $rose(running) |-> $past(run_wr)) else $error("run without start");
  chk_halt_now: assert property (
    halt_wr |=> halt_interrupt_flag && !running) else $error("halt not taken");
  chk_mask_set: assert property (
    mset_wr |=> receive_enable_reg[RXEN_MASK_BIT]) else $error("mask bit not set");
  chk_mask_clr: assert property (
    mclr_wr |=> !receive_enable_reg[RXEN_MASK_BIT]) else $error("mask bit not cleared");
  chk_strobe_run: assert property (
    strobe_out.valid && strobe_out.cmd != CMD_RXON |-> $past(running)) else $error("strobe while stopped");
  chk_wait_ack: assert property (
    wait_q |-> !strobe_out.valid) else $error("strobe before radio ack");
  chk_cca_gate: assert property (
    strobe_out.valid && strobe_out.cmd == CMD_TXONCCA |-> $past(cca_in)) else $error("tx on with busy channel");
endmodule

bind rss_sequencer rss_props u_props (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .cca_in,
  .radio_ack, .strobe_out, .rx_on_pulse_out, .receive_enable_reg, .halt_interrupt_flag, .running);

/* File: verif/rss_radio_model.sv */
// radio control model: acknowledges waiting command strobes.
// assumes strobes arrive on core_clk as one-cycle pulses.
`timescale 1ns/1ps
module rss_radio_model import rss_pkg::*; (
  input wire logic core_clk, // clock
  input wire logic rst_n, // reset, active low
  input wire rss_strobe_s strobe, // command strobe
  input wire logic [3:0] ack_delay, // extra cycles before ack
  output logic radio_ack // one-cycle acknowledge
);
  logic [4:0] cnt_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 5'h00;
      radio_ack <= 1'b0;
    end else begin
      radio_ack <= 1'b0;
      if (strobe.valid && strobe.cmd inside {CMD_RXON, CMD_TXON, CMD_ACK, CMD_ACKPEND, CMD_FLUSHRX,
          CMD_FLUSHTX}) begin
        cnt_q <= {1'b0, ack_delay} + 5'h01;
      end else if (cnt_q == 5'h01) begin
        radio_ack <= 1'b1;
        cnt_q <= 5'h00;
      end else if (cnt_q != 5'h00) begin
        cnt_q <= cnt_q - 5'h01;
      end
    end
  end
endmodule

/* File: verif/tb_radio_strobe_sequencer_ops.sv */
// self-checking bench for the strobe sequencer, driven over apb.
// assumes the radio model acknowledges waiting strobes.
`timescale 1ns/1ps
module tb_radio_strobe_sequencer_ops import rss_pkg::*; ();
  logic core_clk, rst_n, psel, penable, pwrite, cca_in, sfd_in, signal_level_valid_in, radio_ack;
  logic pready, pslverr, err, rx_on_pulse_out, sampled_channel_clear, halt_interrupt_flag, running, t;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] receive_enable_reg, pat;
  logic [3:0] ack_delay;
  rss_strobe_s strobe_out;
  logic [3:0] cmds[$];
  logic [3:0] ecmd[$];
  logic [7:0] prog[$];
  int num_errors = 0;
  int checks_done = 0;

  rss_sequencer uut (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .cca_in, .sfd_in, .signal_level_valid_in, .radio_ack, .strobe_out, .rx_on_pulse_out, .receive_enable_reg,
    .sampled_channel_clear, .halt_interrupt_flag, .running);
  rss_radio_model partner (.core_clk, .rst_n, .strobe(strobe_out), .ack_delay, .radio_ack);

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (strobe_out.valid === 1'b1) begin
      cmds.push_back(strobe_out.cmd);
    end
  end

  task automatic summarize();
    if (num_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", name, e, g);
      num_errors++;
    end
  endtask

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      summarize();
    end
  endtask

  task automatic rdc(input string name, input logic [ADDR_W-1:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(name, e, rd & m);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (running !== 1'b0 && n < 2000);
    if (n >= 2000) begin
      num_errors++;
      summarize();
    end
  endtask

  task automatic run_prog(input logic wait_end);
    apb(1'b1, OFF_PLEN, 32'(prog.size()));
    foreach (prog[i]) apb(1'b1, OFF_PROG + 12'(4 * i), {24'h0, prog[i]});
    cmds = {};
    apb(1'b1, OFF_IMM, {24'h0, IOP_RUN});
    if (wait_end) wait_idle();
  endtask

  task automatic cmp_cmds();
    chk("strobe count", 32'(ecmd.size()), 32'(cmds.size()));
    foreach (ecmd[i]) chk("strobe cmd", 32'(ecmd[i]), 32'(cmds[i]));
  endtask

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    cca_in = 1'b1;
    sfd_in = 1'b0;
    signal_level_valid_in = 1'b0;
    ack_delay = 4'h6;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    rdc("status", OFF_STAT, 32'hffffffff, 32'h0);
    rdc("unmapped", 12'h030, 32'hffffffff, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    // slow radio; strobes after the stop must not appear
    prog = '{8'hd3, 8'hd9, 8'hda, 8'hdb, 8'hdf, 8'hdd, 8'hde, 8'hd6, 8'hd7, 8'hd8, 8'hd4, 8'hd0, 8'hd2, 8'hd3};
    ecmd = '{4'h3, 4'h9, 4'ha, 4'hf, 4'hd, 4'he, 4'h6, 4'h7, 4'h8};
    run_prog(1'b1);
    cmp_cmds();
    rdc("rx enable", OFF_RXEN, 32'h1ff, 32'h120);
    chk("sampled out", 32'h1, {31'h0, sampled_channel_clear});
    // prompt radio, busy channel, mask on transmit enabled
    cca_in <= 1'b0;
    ack_delay <= 4'h0;
    apb(1'b1, OFF_CTRL, 32'h2);
    prog = '{8'hda, 8'hdb, 8'hd5, 8'hd9, 8'hd2};
    ecmd = '{4'h9};
    run_prog(1'b1);
    cmp_cmds();
    rdc("rx enable", OFF_RXEN, 32'h1ff, 32'h020);
    chk("sampled out", 32'h0, {31'h0, sampled_channel_clear});
    // each condition source gets its own on/off signature over the four passes
    for (int lv = 0; lv < 4; lv++) begin
      @(posedge core_clk);
      pat = (lv == 3) ? 8'hff : (lv == 2) ? 8'hf0 : (lv == 1) ? 8'hcc : 8'haa;
      cca_in <= pat[COND_CCA];
      sfd_in <= pat[COND_SFD];
      signal_level_valid_in <= pat[COND_RSSI];
      apb(1'b1, OFF_CTRL, {31'h0, pat[COND_HOST]});
      apb(1'b1, OFF_XVAL, {31'h0, !pat[COND_XZ]});
      apb(1'b1, OFF_YREG, {31'h0, !pat[COND_YZ]});
      apb(1'b1, OFF_ZREG, {31'h0, !pat[COND_ZZ]});
      for (int k = 0; k < 16; k++) begin
        prog = '{8'h10 | 8'(k), 8'hd8, 8'hd2};
        t = (pat[k[2:0]] && k[2:0] != COND_RSVD) ^ k[3];
        run_prog(1'b1);
        chk("skip strobes", {31'h0, !t}, 32'(cmds.size()));
      end
    end
    prog = '{8'h7b, 8'hd8, 8'hd2};
    run_prog(1'b1);
    chk("skip past end", 32'h0, 32'(cmds.size()));
    rdc("stopped", OFF_STAT, 32'h1f03, 32'h0);
    prog = '{8'h02, 8'hd8, 8'hd2};
    run_prog(1'b0);
    repeat (20) @(posedge core_clk);
    rdc("busy wait", OFF_STAT, 32'h3, 32'h1);
    chk("busy strobes", 32'h0, 32'(cmds.size()));
    apb(1'b1, OFF_CTRL, 32'h0);
    wait_idle();
    chk("after wait", 32'h1, 32'(cmds.size()));
    apb(1'b1, OFF_CTRL, 32'h1);
    run_prog(1'b0);
    apb(1'b1, OFF_IMM, {24'h0, IOP_HALT});
    rdc("halted", OFF_STAT, 32'h3, 32'h2);
    apb(1'b1, OFF_STAT, 32'h2);
    rdc("flag cleared", OFF_STAT, 32'h3, 32'h0);
    prog = '{8'hd8, 8'ha2, 8'hd2};
    run_prog(1'b1);
    chk("no label", 32'h1, 32'(cmds.size()));
    prog = '{8'hbb, 8'hd8, 8'ha2, 8'hd2};
    run_prog(1'b0);
    repeat (30) @(posedge core_clk);
    rdc("looping", OFF_STAT, 32'h5, 32'h5);
    apb(1'b1, OFF_CTRL, 32'h0);
    wait_idle();
    chk("loop passes", 32'h1, {31'h0, cmds.size() > 3});
    cmds = {};
    apb(1'b1, OFF_IMM, {24'h0, IOP_RXON});
    repeat (4) @(posedge core_clk);
    ecmd = '{4'h3};
    cmp_cmds();
    apb(1'b1, OFF_IMM, {24'h0, IOP_MASK_CLR});
    rdc("imm clr", OFF_RXEN, 32'h20, 32'h0);
    apb(1'b1, OFF_IMM, {24'h0, IOP_MASK_SET});
    rdc("imm set", OFF_RXEN, 32'h20, 32'h20);
    summarize();
  end
endmodule
